// >>> design/sac_defs.vh
// Functional notes
// RQ1 - extra interrupts after fast slide, enabled default
// RQ2 - enable cleared means no extra interrupts
// RQ3 - extras grow with speed, capped by limit
// RQ4 - limit field bits 6-4, default 100b
// RQ5 - half window N, three-quarter N/2, else 1; the code gives N/4 there (limit bit 6), so 0 for a limit below 4
// RQ6 - window field bits 3-2; slower slide none
// RQ7 - window codes 350, 560, 770, 980 ms
// RQ8 - speedup field bits 1-0 shortens repeat
// RQ9 - speed is distinct sensors per 100 ms
// RQ10 - repeat interval table by sensors and code
// RQ11 - fast base repeat: code 11 fixed values
// RQ12 - set bit forces calibration without base
// RQ13 - bit 7 recalibrates all grouped sensors
// RQ14 - bits 6-0 recalibrate channels 7-1
// RQ15 - bit clears itself when routine completes
// RQ16 - completed recalibration replaces base count
// RQ17 - writing zero neither starts nor aborts
// RQ18 - extras use slider alert path, spaced
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
// ==========================================================
// register map
`define SAC_ADDR_SPEED_CFG 8'h3E
`define SAC_ADDR_RECAL_CTL 8'h3F
`define SAC_SPEED_CFG_RST 8'hC5
`define SAC_RECAL_CTL_RST 8'h00
`define SAC_READ_NONE 8'h00
// ==========================================================
// field positions
`define SAC_BIT_XIRQ_EN 7
`define SAC_XLIM_HI 6
`define SAC_XLIM_LO 4
`define SAC_WIN_HI 3
`define SAC_WIN_LO 2
`define SAC_SCALE_HI 1
`define SAC_SCALE_LO 0
`define SAC_BIT_GROUP_RECAL 7
`define SAC_RECAL_CHANS 8
// ==========================================================
// timing
`define SAC_CLK_PERIOD_NS 5
`define SAC_MS_NS 1000000
`define SAC_MS_CYCLES 18'h30D40
`define SAC_SPEED_WINDOW_MS 7'h64
`define SAC_WIN0_MS 10'h15E
`define SAC_WIN1_MS 10'h230
`define SAC_WIN2_MS 10'h302
`define SAC_WIN3_MS 10'h3D4
`define SAC_SLIDE_MS_MAX 10'h3FF
`define SAC_RPT_35_MS 8'h23
`define SAC_RPT_70_MS 8'h46
`define SAC_RPT_105_MS 8'h69
`define SAC_RPT_140_MS 8'h8C
`endif

// >>> design/sac_recal_chan.v
`timescale 1ns/100ps
`include "sac_defs.vh"

// ==========================================================
// one forced recalibration channel
module sac_recal_chan (
   input wire clock,
   input wire nrst,
   input wire setReq,
   input wire calDone,
   output wire pending,
   output wire baseLoad
);

reg pending_r;
reg baseLoad_r;

// pending bit: set wins over completion
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      pending_r <= 1'b0;
      baseLoad_r <= 1'b0;
   end else begin
      if (setReq) begin
         pending_r <= 1'b1; // RQ12
      end else if (calDone) begin
         pending_r <= 1'b0; // RQ15
      end
      baseLoad_r <= pending_r & calDone; // RQ16
   end
end

assign pending = pending_r;
assign baseLoad = baseLoad_r;

endmodule

// >>> design/sac_slider_accel.v
`timescale 1ns/100ps
`include "sac_defs.vh"

// ==========================================================
// slider speed handling and forced recalibration
module sac_slider_accel #(
   parameter [17:0] MS_CYCLES = `SAC_MS_CYCLES
) (
   input wire clock,
   input wire nrst,
   input wire [7:0] regAddr,
   input wire regWrEn,
   input wire [7:0] regWrData,
   output wire [7:0] regRdData,
   input wire cycleTick,
   input wire slideStart,
   input wire slideEnd,
   input wire [6:0] sliderTouch,
   input wire [7:0] sliderBaseRepeat,
   input wire [7:0] calDone,
   output wire extraIrq,
   output wire [7:0] repeatIntervalMs,
   output wire [2:0] sensorCount,
   output wire [7:0] recalRequest,
   output wire [7:0] baseLoad
);

// ==========================================================
// declarations

// register file and read path
reg [7:0] speedCfg_r;
reg [7:0] rdData_r;
reg [7:0] rdData_nxt;
wire xirqEn;
wire [2:0] extraLimit;
wire [1:0] windowCode;
wire [1:0] speedScale;
wire wrSpeed;
wire wrRecal;
wire [7:0] recalPending;

// millisecond time base
reg [17:0] msCnt_r;
reg msTick_r;
wire msWrap;

// slide timing and extra interrupts
reg slideActive_r;
reg [9:0] slideMs_r;
reg [2:0] extrasLeft_r;
reg [2:0] extrasLeft_nxt;
reg extraIrq_r;
reg [9:0] windowMs;
reg [2:0] earned;
wire [11:0] slide4;
wire [11:0] win2;
wire [11:0] win3;
wire [11:0] win4;
wire slideDone;
wire issueExtra;

// speed window and repeat interval
reg [6:0] winCnt_r;
reg [6:0] seenMask_r;
reg [2:0] sensorCount_r;
reg [7:0] repeatMs_r;
reg [7:0] repeatMs_nxt;
wire winEnd;
wire [6:0] seenNow;
wire [2:0] seenSum [0:7];

// ==========================================================
// register access

// write strobes per register
assign wrSpeed = regWrEn && (regAddr == `SAC_ADDR_SPEED_CFG);
assign wrRecal = regWrEn && (regAddr == `SAC_ADDR_RECAL_CTL);

// fields are used straight from the register, no shadow
// configuration register
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      speedCfg_r <= `SAC_SPEED_CFG_RST; // RQ1 RQ4 RQ6 RQ8
   end else if (wrSpeed) begin
      speedCfg_r <= regWrData;
   end
end

// configuration fields
assign xirqEn = speedCfg_r[`SAC_BIT_XIRQ_EN];
assign extraLimit = speedCfg_r[`SAC_XLIM_HI:`SAC_XLIM_LO];
assign windowCode = speedCfg_r[`SAC_WIN_HI:`SAC_WIN_LO];
assign speedScale = speedCfg_r[`SAC_SCALE_HI:`SAC_SCALE_LO];

// read data mux, unmapped reads as zero
// a pending recal bit reads one until its routine ends
always @* begin
   if (regAddr == `SAC_ADDR_SPEED_CFG) begin
      rdData_nxt = speedCfg_r;
   end else if (regAddr == `SAC_ADDR_RECAL_CTL) begin
      rdData_nxt = recalPending; // RQ17
   end else begin
      rdData_nxt = `SAC_READ_NONE;
   end
end

// read data register, one cycle behind address
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      rdData_r <= `SAC_READ_NONE;
   end else begin
      rdData_r <= rdData_nxt;
   end
end

// ==========================================================
// forced recalibration channels

// bit 7 is the group, bits 6..0 channels 7..1
// a write of zero leaves a pending channel running
genvar gi;
generate
   for (gi = 0; gi < `SAC_RECAL_CHANS; gi = gi + 1) begin : gRecal
      sac_recal_chan uChan (
         .clock(clock),
         .nrst(nrst),
         .setReq(wrRecal & regWrData[gi]), // RQ13 RQ14 RQ17
         .calDone(calDone[gi]),
         .pending(recalPending[gi]),
         .baseLoad(baseLoad[gi])
      );
   end
endgenerate

// ==========================================================
// millisecond time base

// wrap flag for the divider
assign msWrap = (msCnt_r == (MS_CYCLES - 18'h00001));

// divider from the core clock to one millisecond
// free-running, so slide time and speed share one time base
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      msCnt_r <= 18'h00000;
      msTick_r <= 1'b0;
   end else begin
      if (msWrap) begin
         msCnt_r <= 18'h00000;
      end else begin
         msCnt_r <= msCnt_r + 18'h00001;
      end
      msTick_r <= msWrap;
   end
end

// ==========================================================
// slide time measurement

// slide timer in ms, saturates at 1023, just past the longest window of 980
// saturation keeps a very slow slide from wrapping to a fast one
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      slideActive_r <= 1'b0;
      slideMs_r <= 10'h000;
   end else begin
      if (slideStart) begin
         slideActive_r <= 1'b1;
         slideMs_r <= 10'h000;
      end else if (slideEnd) begin
         slideActive_r <= 1'b0;
      end else if (slideActive_r && msTick_r) begin
         if (slideMs_r != `SAC_SLIDE_MS_MAX) begin
            slideMs_r <= slideMs_r + 10'h001;
         end
      end
   end
end

// window length for the selected code
// window lengths are whole milliseconds
always @* begin
   case (windowCode)
      2'b00: windowMs = `SAC_WIN0_MS; // RQ7
      2'b01: windowMs = `SAC_WIN1_MS; // RQ7
      2'b10: windowMs = `SAC_WIN2_MS; // RQ7
      default: windowMs = `SAC_WIN3_MS; // RQ7
   endcase
end

// fractions compared as multiples of four, no division
assign slide4 = {slideMs_r, 2'b00};
assign win2 = {1'b0, windowMs, 1'b0};
assign win3 = win2 + {2'b00, windowMs};
assign win4 = {windowMs, 2'b00};

// extras earned by the slide just ended
// a slide time on the half or three-quarter boundary falls in the longer bin, one at the full window in the shorter
always @* begin
   if (slide4 < win2) begin
      earned = extraLimit; // RQ5 RQ3
   end else if (slide4 < win3) begin
      earned = {1'b0, extraLimit[2:1]}; // RQ5
   end else if (slide4 <= win4) begin
      earned = {2'b00, extraLimit[2]}; // RQ5
   end else begin
      earned = 3'b000; // RQ6
   end
end

// ==========================================================
// extra interrupt issue

// a slide end counts only while a slide is in progress
assign slideDone = slideEnd && slideActive_r;

// reload wins over a tick, so no extra comes from a stale count
assign issueExtra = xirqEn && cycleTick && !slideDone &&
                    (extrasLeft_r != 3'b000); // RQ18 RQ2

// load on slide end, one extra per measurement cycle
always @* begin
   extrasLeft_nxt = extrasLeft_r;
   if (!xirqEn) begin
      extrasLeft_nxt = 3'b000; // RQ2
   end else if (slideDone) begin
      extrasLeft_nxt = earned; // RQ1 RQ4
   end else if (issueExtra) begin
      extrasLeft_nxt = extrasLeft_r - 3'b001; // RQ18
   end
end

// pulse on the slider alert path
// registered so the alert path sees a clean pulse
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      extrasLeft_r <= 3'b000;
      extraIrq_r <= 1'b0;
   end else begin
      extrasLeft_r <= extrasLeft_nxt;
      extraIrq_r <= issueExtra; // RQ18 RQ2
   end
end

// ==========================================================
// slide speed over a 100 ms window

// window end and the sensors seen so far
// a sensor touched in the closing cycle still counts
assign winEnd = msTick_r &&
                (winCnt_r == (`SAC_SPEED_WINDOW_MS - 7'h01));
assign seenNow = seenMask_r | sliderTouch;

// running count of the sensors seen, one adder per sensor
genvar gs;
assign seenSum[0] = 3'b000;
generate
   for (gs = 0; gs < 7; gs = gs + 1) begin : gCount
      assign seenSum[gs + 1] = seenSum[gs] + {2'b00, seenNow[gs]};
   end
endgenerate

// distinct sensors touched per window
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      winCnt_r <= 7'h00;
      seenMask_r <= 7'h00;
      sensorCount_r <= 3'b000;
   end else begin
      if (winEnd) begin
         winCnt_r <= 7'h00;
         seenMask_r <= 7'h00;
         sensorCount_r <= seenSum[7]; // RQ9
      end else begin
         if (msTick_r) begin
            winCnt_r <= winCnt_r + 7'h01;
         end
         seenMask_r <= seenNow; // RQ9
      end
   end
end

// ==========================================================
// repeat interval selection

// interval by sensor count and speedup code
// no sensor or one keeps the normal slider repeat
always @* begin
   repeatMs_nxt = sliderBaseRepeat;
   if (sensorCount_r >= 3'd5) begin
      repeatMs_nxt = `SAC_RPT_35_MS; // RQ10
   end else if ((speedScale == 2'b11) &&
                (sliderBaseRepeat <= `SAC_RPT_105_MS) &&
                (sensorCount_r >= 3'd2)) begin
      case (sensorCount_r)
         3'd2: repeatMs_nxt = `SAC_RPT_140_MS; // RQ11
         3'd3: repeatMs_nxt = `SAC_RPT_105_MS; // RQ11
         default: repeatMs_nxt = `SAC_RPT_70_MS; // RQ11
      endcase
   end else if (sensorCount_r == 3'd4) begin
      if (speedScale == 2'b11) begin
         repeatMs_nxt = `SAC_RPT_70_MS; // RQ10 RQ8
      end else begin
         repeatMs_nxt = `SAC_RPT_35_MS; // RQ10
      end
   end else if (sensorCount_r == 3'd3) begin
      case (speedScale)
         2'b10: repeatMs_nxt = `SAC_RPT_70_MS; // RQ10
         2'b11: repeatMs_nxt = `SAC_RPT_105_MS; // RQ10
         default: repeatMs_nxt = `SAC_RPT_35_MS; // RQ10
      endcase
   end else if (sensorCount_r == 3'd2) begin
      case (speedScale)
         2'b00: repeatMs_nxt = `SAC_RPT_35_MS; // RQ10
         2'b01: repeatMs_nxt = `SAC_RPT_70_MS; // RQ10
         2'b10: repeatMs_nxt = `SAC_RPT_105_MS; // RQ10
         default: repeatMs_nxt = `SAC_RPT_140_MS; // RQ10
      endcase
   end
end

// registered interval for the repeat logic
// resets to the fastest interval, then follows the selection from the next cycle
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      repeatMs_r <= `SAC_RPT_35_MS;
   end else begin
      repeatMs_r <= repeatMs_nxt;
   end
end

// ==========================================================
// outputs
assign regRdData = rdData_r;
assign extraIrq = extraIrq_r;
assign repeatIntervalMs = repeatMs_r;
assign sensorCount = sensorCount_r;

// recalibration state comes from the channel flip-flops
assign recalRequest = recalPending;

endmodule

// >>> testbench/sac_cal_model.sv
`timescale 1ns/100ps
// ==========================================================
// calibration engine: finishes pending channels after a delay
module sac_cal_model #(
   parameter DELAY = 20
) (
   input wire clock,
   input wire nrst,
   input wire [7:0] recalRequest,
   output reg [7:0] calDone
);
   integer cnt_r;
   // all pending channels finish together, one pulse each
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 0;
         calDone <= 8'h00;
      end else begin
         calDone <= 8'h00;
         if (recalRequest == 8'h00)
            cnt_r <= 0;
         else if (cnt_r == DELAY) begin
            calDone <= recalRequest;
            cnt_r <= 0;
         end else
            cnt_r <= cnt_r + 1;
      end
   end
endmodule

// >>> testbench/sac_slider_accel_monitor.sv
`timescale 1ns/100ps
// ==========================================================
// port checker for slider speed and forced recalibration
module sac_slider_accel_monitor #(
   parameter [17:0] MS_CYCLES = 18'd20
) (
   input wire clock,
   input wire nrst,
   input wire [7:0] regAddr,
   input wire regWrEn,
   input wire [7:0] regWrData,
   input wire [7:0] regRdData,
   input wire cycleTick,
   input wire [7:0] sliderBaseRepeat,
   input wire [7:0] calDone,
   input wire extraIrq,
   input wire [7:0] repeatIntervalMs,
   input wire [2:0] sensorCount,
   input wire [7:0] recalRequest,
   input wire [7:0] baseLoad
);
   reg cfgEn_r;
   reg [7:0] doneHit_r;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // shadow of the enable bit and of finished pending channels
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfgEn_r <= 1'b1;
         doneHit_r <= 8'h00;
      end else begin
         if (regWrEn && regAddr == 8'h3E)
            cfgEn_r <= regWrData[7];
         doneHit_r <= calDone & recalRequest;
      end
   end
   cfg_readback_a: assert property (
      regWrEn && regAddr == 8'h3E ##1 regAddr == 8'h3E
      |=> regRdData == $past(regWrData, 2)) else $error("config readback");
   recal_set_a: assert property (
      regWrEn && regAddr == 8'h3F |=>
      (recalRequest & $past(regWrData)) == $past(regWrData))
      else $error("recal bit not set");
   recal_noself_a: assert property (
      !(regWrEn && regAddr == 8'h3F) |=>
      (recalRequest & ~$past(recalRequest)) == 8'h00)
      else $error("recal bit rose without write");
   recal_clear_a: assert property (
      (|(calDone & recalRequest)) && !regWrEn |=>
      (recalRequest & doneHit_r) == 8'h00) else $error("recal not cleared");
   base_load_a: assert property (
      baseLoad == doneHit_r) else $error("base load mismatch");
   irq_off_a: assert property (
      !cfgEn_r |=> !extraIrq) else $error("extra irq while disabled");
   irq_tick_a: assert property (
      extraIrq |-> $past(cycleTick) && !$past(extraIrq))
      else $error("extra irq not after tick");
   fast_repeat_a: assert property (
      sensorCount >= 3'd5 |=> repeatIntervalMs == 8'h23)
      else $error("fast repeat not 35");
   one_sensor_a: assert property (
      sensorCount <= 3'd1 |=> repeatIntervalMs == $past(sliderBaseRepeat))
      else $error("slow repeat not base");
endmodule

bind sac_slider_accel sac_slider_accel_monitor #(.MS_CYCLES(MS_CYCLES))
   sac_mon_inst (.clock(clock), .nrst(nrst), .regAddr(regAddr),
   .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
   .cycleTick(cycleTick), .sliderBaseRepeat(sliderBaseRepeat),
   .calDone(calDone), .extraIrq(extraIrq),
   .repeatIntervalMs(repeatIntervalMs), .sensorCount(sensorCount),
   .recalRequest(recalRequest), .baseLoad(baseLoad));

// >>> testbench/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for slider speed and forced recalibration
module testbench;
   localparam [17:0] MS = 18'h0000A;
   reg clock = 1'b0;
   reg nrst = 1'b0;
   reg [7:0] regAddr = 8'h00;
   reg regWrEn = 1'b0;
   reg [7:0] regWrData = 8'h00;
   reg cycleTick = 1'b0;
   reg slideStart = 1'b0;
   reg slideEnd = 1'b0;
   reg [6:0] sliderTouch = 7'h00;
   reg [7:0] baseSeen = 8'h00;
   reg [7:0] baseRepeat = 8'h50;
   wire [7:0] regRdData, calDone, repeatIntervalMs, recalRequest, baseLoad;
   wire extraIrq;
   wire [2:0] sensorCount;
   integer num_errors = 0;
   integer cmp_count = 0;
   integer irqSeen = 0;
   always #2.5 clock = ~clock;
   // collect base loads and extra interrupts
   always @(posedge clock) begin
      baseSeen <= baseSeen | baseLoad;
      if (extraIrq === 1'b1)
         irqSeen <= irqSeen + 1;
   end
   sac_slider_accel #(.MS_CYCLES(MS)) sac_slider_accel_inst (
      .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdData(regRdData),
      .cycleTick(cycleTick), .slideStart(slideStart), .slideEnd(slideEnd),
      .sliderTouch(sliderTouch), .sliderBaseRepeat(baseRepeat),
      .calDone(calDone), .extraIrq(extraIrq),
      .repeatIntervalMs(repeatIntervalMs), .sensorCount(sensorCount),
      .recalRequest(recalRequest), .baseLoad(baseLoad));
   sac_cal_model sac_cal_model_inst (.clock(clock), .nrst(nrst),
      .recalRequest(recalRequest), .calDone(calDone));
   task check8(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clock);
         regAddr = a;
         regWrData = d;
         regWrEn = 1'b1;
         @(negedge clock);
         regWrEn = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      begin
         @(negedge clock);
         regAddr = a;
         @(negedge clock);
         check8(regRdData, exp);
      end
   endtask
   task give_verdict;
      begin
         $display("compares %0d mismatches %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task t_regs;
      begin
         rd(8'h3E, 8'hC5);
         rd(8'h3F, 8'h00);
         rd(8'h40, 8'h00);
         $display("register reset test done");
      end
   endtask
   task t_recal;
      integer i;
      begin
         wr(8'h3F, 8'hA5);
         wr(8'h3F, 8'h00);
         rd(8'h3F, 8'hA5);
         check8(recalRequest, 8'hA5);
         i = 0;
         while (recalRequest !== 8'h00 && i < 100) begin
            @(negedge clock);
            i = i + 1;
         end
         check8(recalRequest, 8'h00);
         if (i == 100)
            give_verdict;
         rd(8'h3F, 8'h00);
         check8(baseSeen, 8'hA5);
         $display("recal test done");
      end
   endtask
   // one slide of t ms, then ticks; counts the extra pulses
   task slide(input en, input [2:0] n, input [1:0] w, input integer t);
      integer wm, e, i, s0;
      begin
         wr(8'h3E, {en, n, w, 2'b01});
         wm = 350 + 210 * w;
         e = (4 * t < 2 * wm) ? n : (4 * t < 3 * wm) ? n / 2 :
            (4 * t <= 4 * wm) ? n[2] : 0;
         if (!en)
            e = 0;
         @(negedge clock);
         slideStart = 1'b1;
         @(negedge clock);
         slideStart = 1'b0;
         repeat (t * MS) @(negedge clock);
         slideEnd = 1'b1;
         @(negedge clock);
         slideEnd = 1'b0;
         s0 = irqSeen;
         for (i = 0; i < 9; i = i + 1) begin
            cycleTick = 1'b1;
            @(negedge clock);
            cycleTick = 1'b0;
            repeat (3) @(negedge clock);
         end
         s0 = irqSeen - s0;
         check8(s0[7:0], e[7:0]);
      end
   endtask
   task t_extra;
      begin
         slide(1'b1, 3'h7, 2'h0, 100);
         slide(1'b1, 3'h7, 2'h0, 200);
         slide(1'b1, 3'h5, 2'h0, 300);
         slide(1'b1, 3'h3, 2'h0, 300);
         slide(1'b1, 3'h7, 2'h0, 400);
         slide(1'b1, 3'h2, 2'h1, 250);
         slide(1'b1, 3'h4, 2'h2, 450);
         slide(1'b1, 3'h6, 2'h3, 400);
         slide(1'b0, 3'h7, 2'h0, 100);
         $display("extra interrupt test done");
      end
   endtask
   // k sensors held over two windows with speedup code s
   task speed(input [1:0] s, input integer k);
      integer m, e;
      begin
         wr(8'h3E, {6'h31, s});
         sliderTouch = 7'h7F >> (7 - k);
         repeat (200 * MS + 20) @(negedge clock);
         m = 3 - k + s;
         e = (k == 1) ? baseRepeat : 35 * ((m < 1) ? 1 : m);
         check8({5'h00, sensorCount}, k[7:0]);
         check8(repeatIntervalMs, e[7:0]);
      end
   endtask
   task t_speed;
      integer s, k;
      begin
         for (s = 0; s < 4; s = s + 1)
            for (k = 2; k < 6; k = k + 1)
               speed(s[1:0], k);
         speed(2'h3, 1);
         baseRepeat = 8'hC8;
         speed(2'h3, 2);
         speed(2'h0, 1);
         speed(2'h2, 7);
         sliderTouch = 7'h00;
         $display("repeat speed test done");
      end
   endtask
   initial begin
      repeat (20) @(negedge clock);
      nrst = 1'b1;
      t_regs;
      t_recal;
      t_extra;
      t_speed;
      give_verdict;
   end
endmodule
